// *** adcs_params.svh ***
`ifndef ADCS_PARAMS_SVH
`define ADCS_PARAMS_SVH

// Result width and code limits
`define ADCS_RES_BITS 14
`define ADCS_CODE_MAX 16'h3fff
`define ADCS_CODE_MIN 16'h0000

// Clock rate and conversion time; the cycle count is rounded down as a longest time
`define ADCS_CLK_MHZ 250
`define ADCS_CONV_TIME_NS 1600
`define ADCS_CONV_CYC ((`ADCS_CONV_TIME_NS * `ADCS_CLK_MHZ) / 1000)

// Falling edges per frame, plain and with the leading start bit
`define ADCS_BITS_PLAIN 4'he
`define ADCS_BITS_BUSY 4'hf

// Result buffer depth
`define ADCS_FIFO_DEPTH 4

// Synchroniser bit positions for the pin inputs
`define ADCS_SYN_CNV 0
`define ADCS_SYN_SDI 1
`define ADCS_SYN_SCK 2

`endif

// *** adcs_pkg.sv ***
package adcs_pkg;

  // Converter phase, Gray coded along acquire, convert, push, read
  typedef enum logic [1:0] {
    ST_ACQ  = 2'b00,
    ST_CONV = 2'b01,
    ST_PUSH = 2'b11,
    ST_READ = 2'b10
  } adcs_state_t;

  // Interface mode picked at each convert strobe rising edge that starts a conversion
  typedef enum logic {
    MODE_CHAIN = 1'b0,
    MODE_CS    = 1'b1
  } adcs_mode_t;

endpackage

// *** adcs_stream_if.sv ***
`timescale 1ns/1ns
// Valid/ready word stream between the converter core and its result buffer
interface adcs_stream_if #(
  parameter int WIDTH = 14
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// *** adcs_fifo.sv ***
`timescale 1ns/1ns
// Small synchronous FIFO with honest full and empty
module adcs_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 4
) (
  input wire logic clk_in,
  input wire logic rst_in,
  adcs_stream_if.snk in_s,
  adcs_stream_if.src out_s
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr;
  logic [AW-1:0] rd_ptr_ff, nxt_rd_ptr;
  logic [AW:0] count_ff, nxt_count;
  logic do_push, do_pop;

  // Pointer wrap shared by both ends
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  assign in_s.ready = (count_ff != (AW+1)'(DEPTH));
  assign out_s.valid = (count_ff != '0);
  assign out_s.data = mem_ff[rd_ptr_ff];
  assign do_push = in_s.valid && in_s.ready;
  assign do_pop = out_s.valid && out_s.ready;

  // Next pointers and fill level
  always_comb begin
    nxt_wr_ptr = do_push ? bump(wr_ptr_ff) : wr_ptr_ff;
    nxt_rd_ptr = do_pop ? bump(rd_ptr_ff) : rd_ptr_ff;
    nxt_count = count_ff;
    if (do_push && !do_pop) begin
      nxt_count = count_ff + 1'b1;
    end else if (do_pop && !do_push) begin
      nxt_count = count_ff - 1'b1;
    end
  end

  // Storage has no reset; only the pointers and fill count need a known start
  always_ff @(posedge clk_in) begin
    if (do_push) begin
      mem_ff[wr_ptr_ff] <= in_s.data;
    end
    if (rst_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff <= nxt_count;
    end
  end
endmodule

// *** adcs_core.sv ***
`timescale 1ns/1ns
`include "adcs_params.svh"
// Summary of operation
// - Convert strobe rise samples select pin: high picks select mode, low chain mode.
// - Select pin tied to convert strobe always resolves to chain mode.
// - Optional start bit ahead of the result acts as a busy flag.
// - Select mode: busy enabled if strobe or select pin is low at conversion end.
// - Chain mode: busy enabled if shift clock is high at the strobe rise.
// - Converter powers down after every conversion; power follows conversion rate.
// - Chain mode uses the select pin as cascade input, shifting like a register.
// - Three-wire select mode uses strobe, shift clock and output; strobe frames readback.
// - Four-wire select mode uses the select pin to frame readback independently.
// - Strobe rise starts a conversion and floats the output; internal clock finishes.
// - Result leaves MSB first on falling edges; floats on deselect, and in select mode also after the 14th (15th with busy).
// - Straight binary 0000 to 3fff, clamped at both ends.
// - With busy enabled, output goes from float to low at conversion end.
module adcs_core #(
  parameter int CONV_CYC = `ADCS_CONV_CYC,
  parameter int FIFO_DEPTH = `ADCS_FIFO_DEPTH
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic convert_strobe_in,
  input wire logic serial_in_select_in,
  input wire logic shift_clk_in,
  input wire logic [15:0] sample_level_in,
  output logic serial_result_out_out,
  output logic serial_result_oe_out,
  output logic powered_down_out,
  output logic chain_mode_out
);
  localparam int RB = `ADCS_RES_BITS;

  // Pin synchronisers: stage one feeds stage two only, stage three gives edges
  logic [2:0] sync1_ff, sync2_ff, sync3_ff;
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      sync3_ff <= 3'h0;
    end else begin
      sync1_ff <= {shift_clk_in, serial_in_select_in, convert_strobe_in};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  logic cnv_s, sdi_s, sck_s, sdi_prev, cnv_rise, sck_fall, sck_rise, selected;
  assign cnv_s = sync2_ff[`ADCS_SYN_CNV];
  assign sdi_s = sync2_ff[`ADCS_SYN_SDI];
  assign sck_s = sync2_ff[`ADCS_SYN_SCK];
  assign sdi_prev = sync3_ff[`ADCS_SYN_SDI];
  assign cnv_rise = cnv_s && !sync3_ff[`ADCS_SYN_CNV];
  assign sck_fall = !sck_s && sync3_ff[`ADCS_SYN_SCK];
  assign sck_rise = sck_s && !sync3_ff[`ADCS_SYN_SCK];
  // Select mode readback is framed by strobe low (3-wire) or select low (4-wire)
  assign selected = !(cnv_s && sdi_s);

  function automatic logic [RB-1:0] clamp_code(input logic [15:0] lvl);
    if (lvl[15]) begin
      clamp_code = RB'(`ADCS_CODE_MIN);
    end else if (lvl > `ADCS_CODE_MAX) begin
      clamp_code = RB'(`ADCS_CODE_MAX);
    end else begin
      clamp_code = lvl[RB-1:0];
    end
  endfunction

  adcs_stream_if #(.WIDTH(RB)) push_s ();
  adcs_stream_if #(.WIDTH(RB)) pop_s ();

  adcs_fifo #(.WIDTH(RB), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in(mclk_in),
    .rst_in(rst_in),
    .in_s(push_s),
    .out_s(pop_s)
  );

  adcs_pkg::adcs_state_t state_ff, nxt_state;
  adcs_pkg::adcs_mode_t mode_ff, nxt_mode;
  logic busy_en_ff, nxt_busy_en;
  logic [15:0] conv_cnt_ff, nxt_conv_cnt;
  logic [RB-1:0] held_ff, nxt_held;
  logic [RB:0] shreg_ff, nxt_shreg;
  logic [3:0] bits_ff, nxt_bits;
  logic loaded_ff, nxt_loaded;
  logic sel_seen_ff, nxt_sel_seen;
  logic sdi_cap_ff, nxt_sdi_cap;
  logic sdo_ff, nxt_sdo, oe_ff, nxt_oe, pwrdn_ff, nxt_pwrdn, chain_ff, nxt_chain;
  logic start, pop_load;

  // A new strobe rise is ignored while the converter is still busy
  assign start = cnv_rise && (state_ff != adcs_pkg::ST_CONV) && (state_ff != adcs_pkg::ST_PUSH);
  assign push_s.valid = (state_ff == adcs_pkg::ST_PUSH);
  assign push_s.data = held_ff;
  assign pop_s.ready = (state_ff == adcs_pkg::ST_READ) && !loaded_ff;
  assign pop_load = pop_s.ready && pop_s.valid;

  // Conversion sequencing and readback shifting
  always_comb begin
    nxt_state = state_ff;
    nxt_mode = mode_ff;
    nxt_busy_en = busy_en_ff;
    nxt_conv_cnt = conv_cnt_ff;
    nxt_held = held_ff;
    nxt_shreg = shreg_ff;
    nxt_bits = bits_ff;
    nxt_loaded = loaded_ff;
    nxt_sel_seen = sel_seen_ff;
    nxt_sdi_cap = sck_rise ? sdi_s : sdi_cap_ff;
    if (start) begin
      nxt_state = adcs_pkg::ST_CONV;
      nxt_conv_cnt = 16'(CONV_CYC - 1);
      nxt_held = clamp_code(sample_level_in);
      nxt_loaded = 1'b0;
      nxt_sel_seen = 1'b0;
      nxt_mode = sdi_prev ? adcs_pkg::MODE_CS : adcs_pkg::MODE_CHAIN;
      nxt_busy_en = !sdi_prev && sck_s;
    end else begin
      case (state_ff)
        adcs_pkg::ST_CONV: begin
          if (conv_cnt_ff == 16'h0000) begin
            nxt_state = adcs_pkg::ST_PUSH;
          end else begin
            nxt_conv_cnt = conv_cnt_ff - 16'h0001;
          end
        end
        adcs_pkg::ST_PUSH: begin
          // Stalls here while the buffer is full
          if (push_s.ready) begin
            nxt_state = adcs_pkg::ST_READ;
            if (mode_ff == adcs_pkg::MODE_CS) begin
              nxt_busy_en = selected;
            end
          end
        end
        adcs_pkg::ST_READ: begin
          if (pop_load) begin
            nxt_shreg = busy_en_ff ? {1'b0, pop_s.data} : {pop_s.data, 1'b0};
            nxt_bits = busy_en_ff ? `ADCS_BITS_BUSY : `ADCS_BITS_PLAIN;
            nxt_loaded = 1'b1;
          end else if (loaded_ff) begin
            if (mode_ff == adcs_pkg::MODE_CHAIN) begin
              if (!cnv_s) begin
                nxt_state = adcs_pkg::ST_ACQ;
              end else if (sck_fall) begin
                nxt_shreg = busy_en_ff ? {shreg_ff[RB-1:0], sdi_cap_ff}
                                       : {shreg_ff[RB-1:1], sdi_cap_ff, 1'b0};
              end
            end else begin
              nxt_sel_seen = sel_seen_ff || selected;
              if ((sel_seen_ff && !selected) || bits_ff == 4'h0) begin
                nxt_state = adcs_pkg::ST_ACQ;
              end else if (sck_fall && selected) begin
                nxt_shreg = {shreg_ff[RB-1:0], 1'b0};
                nxt_bits = bits_ff - 4'h1;
              end
            end
          end
        end
        default: begin
          nxt_state = adcs_pkg::ST_ACQ;
        end
      endcase
    end
  end

  // Pin and status outputs, computed ahead so each leaves a flip-flop
  always_comb begin
    nxt_sdo = nxt_shreg[RB];
    nxt_oe = 1'b0;
    if (nxt_state == adcs_pkg::ST_READ && nxt_loaded) begin
      if (mode_ff == adcs_pkg::MODE_CHAIN) begin
        nxt_oe = cnv_s;
      end else begin
        nxt_oe = (nxt_bits != 4'h0) && (busy_en_ff || selected);
      end
    end
    nxt_pwrdn = (nxt_state != adcs_pkg::ST_CONV) && (nxt_state != adcs_pkg::ST_PUSH);
    nxt_chain = (nxt_mode == adcs_pkg::MODE_CHAIN);
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_ff <= adcs_pkg::ST_ACQ;
      mode_ff <= adcs_pkg::MODE_CS;
      busy_en_ff <= 1'b0;
      conv_cnt_ff <= 16'h0000;
      held_ff <= 14'h0000;
      shreg_ff <= 15'h0000;
      bits_ff <= 4'h0;
      loaded_ff <= 1'b0;
      sel_seen_ff <= 1'b0;
      sdi_cap_ff <= 1'b0;
      sdo_ff <= 1'b0;
      oe_ff <= 1'b0;
      pwrdn_ff <= 1'b1;
      chain_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      mode_ff <= nxt_mode;
      busy_en_ff <= nxt_busy_en;
      conv_cnt_ff <= nxt_conv_cnt;
      held_ff <= nxt_held;
      shreg_ff <= nxt_shreg;
      bits_ff <= nxt_bits;
      loaded_ff <= nxt_loaded;
      sel_seen_ff <= nxt_sel_seen;
      sdi_cap_ff <= nxt_sdi_cap;
      sdo_ff <= nxt_sdo;
      oe_ff <= nxt_oe;
      pwrdn_ff <= nxt_pwrdn;
      chain_ff <= nxt_chain;
    end
  end

  assign serial_result_out_out = sdo_ff;
  assign serial_result_oe_out = oe_ff;
  assign powered_down_out = pwrdn_ff;
  assign chain_mode_out = chain_ff;

  // Checks on mode choice, busy, framing and power
  property p_mode_pick;
    @(posedge mclk_in) disable iff (rst_in)
    start |=> (mode_ff == ($past(sdi_prev) ? adcs_pkg::MODE_CS : adcs_pkg::MODE_CHAIN));
  endproperty
  a_mode_pick: assert property (p_mode_pick) else $error("mode not taken from select");

  property p_tied_chain;
    @(posedge mclk_in) disable iff (rst_in)
    start && sdi_s && !sdi_prev |=> chain_mode_out;
  endproperty
  a_tied_chain: assert property (p_tied_chain) else $error("tied select not chain");

  property p_chain_busy;
    @(posedge mclk_in) disable iff (rst_in)
    start && !sdi_prev |=> busy_en_ff == $past(sck_s);
  endproperty
  a_chain_busy: assert property (p_chain_busy) else $error("chain busy not from clock");

  property p_cs_busy;
    @(posedge mclk_in) disable iff (rst_in)
    state_ff == adcs_pkg::ST_PUSH && push_s.ready && mode_ff == adcs_pkg::MODE_CS && !start
      |=> busy_en_ff == $past(selected);
  endproperty
  a_cs_busy: assert property (p_cs_busy) else $error("select busy wrong at end");

  property p_float_start;
    @(posedge mclk_in) disable iff (rst_in)
    start |=> !oe_ff [*2];
  endproperty
  a_float_start: assert property (p_float_start) else $error("output driven at start");

  property p_power;
    @(posedge mclk_in) disable iff (rst_in)
    $rose(state_ff == adcs_pkg::ST_READ) |-> pwrdn_ff ##1 pwrdn_ff || start;
  endproperty
  a_power: assert property (p_power) else $error("not powered down after conversion");

  property p_last_bit;
    @(posedge mclk_in) disable iff (rst_in)
    state_ff == adcs_pkg::ST_READ && mode_ff == adcs_pkg::MODE_CS && loaded_ff && !start
      && sck_fall && selected && bits_ff == 4'h1 && sel_seen_ff |=> !oe_ff && bits_ff == 4'h0;
  endproperty
  a_last_bit: assert property (p_last_bit) else $error("output not floated after last bit");

  property p_busy_low;
    @(posedge mclk_in) disable iff (rst_in)
    pop_load && busy_en_ff && !start |=> oe_ff && !sdo_ff;
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("busy start bit not low");

  property p_cascade;
    @(posedge mclk_in) disable iff (rst_in)
    state_ff == adcs_pkg::ST_READ && mode_ff == adcs_pkg::MODE_CHAIN && loaded_ff && cnv_s
      && sck_fall && !start |=> (busy_en_ff ? shreg_ff[0] : shreg_ff[1]) == $past(sdi_cap_ff);
  endproperty
  a_cascade: assert property (p_cascade) else $error("cascade bit not shifted in");

  c_cs_read: cover property (@(posedge mclk_in) disable iff (rst_in)
    mode_ff == adcs_pkg::MODE_CS && bits_ff == 4'h1 ##1 bits_ff == 4'h0);
  c_chain_busy: cover property (@(posedge mclk_in) disable iff (rst_in)
    chain_mode_out && busy_en_ff && oe_ff);
  c_fifo_stall: cover property (@(posedge mclk_in) disable iff (rst_in)
    state_ff == adcs_pkg::ST_PUSH && !push_s.ready);
endmodule

// *** adcs_host.sv ***
`timescale 1ns/1ns
// Host side of the serial link: strobe, select and shift clock pins
module adcs_host (
  input wire logic mclk_in,
  input wire logic sdo_in,
  input wire logic oe_in,
  output logic cnv_out,
  output logic sel_out,
  output logic sck_out,
  output logic [31:0] word_out,
  output logic word_valid_out
);
  logic line;

  // Pull-up on the data line, so a released output never reads as a start bit
  assign line = oe_in ? sdo_in : 1'b1;

  // Pins idle; shift clock stands still low between frames
  initial begin
    cnv_out = 1'b0;
    sel_out = 1'b1;
    sck_out = 1'b0;
    word_out = 32'h0000_0000;
    word_valid_out = 1'b0;
  end

  task automatic pins(input logic c, input logic s, input logic k);
    @(posedge mclk_in);
    cnv_out <= c;
    sel_out <= s;
    sck_out <= k;
  endtask

  // MSB first
  // Shift clock has its own 125 ns timer, so its phase is unrelated to the core clock
  task automatic read(input int n);
    logic [31:0] w;
    w = 32'h0000_0000;
    for (int i = 0; i < n; i++) begin
      #63 sck_out <= 1'b1;
      #62 w = {w[30:0], line};
      sck_out <= 1'b0;
    end
    #63;
    @(posedge mclk_in);
    word_out <= w;
    word_valid_out <= 1'b1;
    @(posedge mclk_in);
    word_valid_out <= 1'b0;
  endtask
endmodule

// *** tb.sv ***
`timescale 1ns/1ns
module tb;
  logic mclk_in;
  logic rst_in;
  logic [15:0] level;
  logic convert_strobe, sel, sck, serial_result_out, oe, pd, chain, word_valid;
  logic [31:0] word;
  logic [31:0] seed;
  logic [31:0] exp_q[$];
  logic [15:0] lv[4];
  int mismatches;
  int tests_run;
  int test_no;

  // Core clock, 4 ns period
  always #2 mclk_in = ~mclk_in;

  // Short conversion count keeps the run brief
  adcs_core #(.CONV_CYC(8), .FIFO_DEPTH(4)) DUT (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .convert_strobe_in(convert_strobe),
    .serial_in_select_in(sel),
    .shift_clk_in(sck),
    .sample_level_in(level),
    .serial_result_out_out(serial_result_out),
    .serial_result_oe_out(oe),
    .powered_down_out(pd),
    .chain_mode_out(chain)
  );

  adcs_host host (
    .mclk_in(mclk_in),
    .sdo_in(serial_result_out),
    .oe_in(oe),
    .cnv_out(convert_strobe),
    .sel_out(sel),
    .sck_out(sck),
    .word_out(word),
    .word_valid_out(word_valid)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Straight binary, clamped at both ends
  function automatic logic [13:0] clamp(input logic [15:0] l);
    if (l[15]) return 14'h0000;
    if (l > 16'h3fff) return 14'h3fff;
    return l[13:0];
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Each word read by the host is matched to the oldest expectation
  always @(posedge mclk_in) begin
    if (word_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        mismatches++;
        $display("unexpected at %0t got %h exp %h", $time, word, 32'h0);
      end else begin
        chk(word, exp_q.pop_front());
      end
    end
  end

  // One conversion and readback; arguments pick mode, busy and framing
  task automatic scen(input logic tied, s0, k0, s1, c1, ps, pc, cm, busy, input int n,
                      input logic [15:0] lvl);
    logic [31:0] full;
    int i;
    full = busy ? {1'b0, clamp(lvl), 17'h1ffff} : {clamp(lvl), 18'h3ffff};
    host.pins(1'b0, tied ? 1'b0 : s0, k0);
    level <= lvl;
    repeat (4) @(posedge mclk_in);
    host.pins(1'b1, s0, k0);
    repeat (6) @(negedge mclk_in);
    chk({31'h0, pd}, 32'h0);
    host.pins(c1, s1, 1'b0);
    i = 0;
    // Bounded wait for the end of conversion
    while (pd !== 1'b1 && i < 200) begin
      @(negedge mclk_in);
      i++;
    end
    if (i == 200) begin
      mismatches++;
      finish_test();
    end
    repeat (3) @(negedge mclk_in);
    chk({31'h0, pd}, 32'h1);
    chk({31'h0, chain}, {31'h0, cm});
    chk({31'h0, oe}, {31'h0, busy | cm});
    exp_q.push_back(full >> (32 - n));
    host.pins(pc, ps, 1'b0);
    host.read(n);
    host.pins(cm ? 1'b0 : 1'b1, 1'b1, 1'b0);
    repeat (8) @(negedge mclk_in);
    chk({31'h0, oe}, 32'h0);
    test_no++;
    $display("test %0d done", test_no);
  endtask

  // Main sequence; every mode and busy source is visited once at least
  initial begin
    mclk_in = 1'b0;
    rst_in = 1'b1;
    level = 16'h0000;
    seed = 32'h116c;
    mismatches = 0;
    tests_run = 0;
    test_no = 0;
    lv = '{16'hffff, 16'h4000, 16'h3fff, 16'h0000};
    repeat (2) @(posedge mclk_in);
    rst_in <= 1'b0;
    repeat (4) @(negedge mclk_in);
    chk({31'h0, oe}, 32'h0);
    chk({31'h0, pd}, 32'h1);
    chk({31'h0, chain}, 32'h0);
    foreach (lv[j]) begin
      scen(0, 1, 0, 1, 1, 1, 0, 0, 0, 14, lv[j]);
    end
    seed = lfsr(seed);
    scen(0, 1, 0, 0, 1, 0, 1, 0, 1, 15, seed[15:0]);
    seed = lfsr(seed);
    scen(0, 1, 0, 1, 0, 1, 0, 0, 1, 15, seed[15:0]);
    seed = lfsr(seed);
    scen(0, 1, 0, 1, 1, 0, 1, 0, 0, 14, seed[15:0]);
    seed = lfsr(seed);
    scen(0, 1, 0, 1, 1, 0, 1, 0, 0, 5, seed[15:0]);
    seed = lfsr(seed);
    scen(0, 0, 0, 1, 1, 1, 1, 1, 0, 18, seed[15:0]);
    seed = lfsr(seed);
    scen(0, 0, 1, 1, 1, 1, 1, 1, 1, 15, seed[15:0]);
    seed = lfsr(seed);
    scen(1, 1, 0, 1, 1, 1, 1, 1, 0, 18, seed[15:0]);
    repeat (20) @(posedge mclk_in);
    if (exp_q.size() != 0) begin
      mismatches++;
    end
    finish_test();
  end
endmodule
